// file: siodc_pkg.sv
// Shared constants for the sensor I/O, diagnostic and control register block.
package siodc_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ = 100;
    localparam int DRDY_MIN_US = 100;
    localparam int DRDY_MAX_US = 200;
    // Aim at the middle of the allowed window so clock tolerance cannot push it out.
    localparam int DRDY_PULSE_CYCLES = ((DRDY_MIN_US + DRDY_MAX_US) / 2) * CLK_MHZ;

    // ==========================================================
    // Serial frame layout
    // ==========================================================
    localparam int FRAME_BITS = 16;
    localparam int FRAME_WRITE_BIT = 15;
    localparam logic [4:0] FRAME_LEN = 5'h10;

    // ==========================================================
    // Register byte addresses (low byte; high byte is address plus one)
    // ==========================================================
    localparam logic [6:0] ADDR_ALARM_CONTROL = 7'h28;
    localparam logic [6:0] ADDR_ANALOG_OUT_CODE = 7'h30;
    localparam logic [6:0] ADDR_LINE_DIRECTION_LEVEL = 7'h32;
    localparam logic [6:0] ADDR_MISC_TEST_READY_CONTROL = 7'h34;
    localparam logic [6:0] ADDR_DIAGNOSTIC_FLAGS = 7'h3C;
    localparam logic [6:0] ADDR_GLOBAL_COMMAND = 7'h3E;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int LINE_DIR_LSB = 0;
    localparam int LINE_LVL_LSB = 8;
    localparam int MISC_READY_SEL = 0;
    localparam int MISC_READY_POL = 1;
    localparam int MISC_READY_EN = 2;
    localparam int MISC_STIM_POS = 8;
    localparam int MISC_STIM_NEG = 9;
    localparam int MISC_SELF_TEST = 10;
    localparam int MISC_MEM_TEST = 11;
    localparam int ALARM_SEL = 0;
    localparam int ALARM_POL = 1;
    localparam int ALARM_EN = 2;
    localparam int GLOBAL_DAC_LATCH = 2;
    localparam int DIAG_SUPPLY_LOW = 0;
    localparam int DIAG_SUPPLY_HIGH = 1;
    localparam int DIAG_FLASH_UPDATE = 2;
    localparam int DIAG_COMM_FAIL = 3;
    localparam int DIAG_OVERRANGE = 4;
    localparam int DIAG_SELF_TEST = 5;
    localparam int DIAG_MEM_TEST = 6;
    localparam int DIAG_ALARM1 = 8;
    localparam int DIAG_ALARM2 = 9;

    // ==========================================================
    // Writable masks and reset values
    // ==========================================================
    localparam logic [15:0] LINE_MASK = 16'h0303;
    localparam logic [15:0] MISC_MASK = 16'h0F07;
    localparam logic [15:0] DAC_MASK = 16'h0FFF;
    localparam logic [15:0] ALARM_MASK = 16'h0007;
    localparam logic [15:0] LINE_RST = 16'h0000;
    localparam logic [15:0] MISC_RST = 16'h0000;
    localparam logic [11:0] DAC_RST = 12'h000;
    localparam logic [2:0] ALARM_RST = 3'h0;
    localparam logic [15:0] DIAG_RST = 16'h0000;

    // ==========================================================
    // Test sequencer states
    // ==========================================================
    typedef enum logic [2:0] {
        SIODC_IDLE = 3'b001,
        SIODC_SELF = 3'b010,
        SIODC_MEM = 3'b100
    } siodc_test_t;

endpackage

// file: siodc_ready_pulse.sv
// Data-ready pulse stretcher: one fixed-width pulse per new sample that arrives while no pulse is running.
`timescale 1ns/1ps

module siodc_ready_pulse #(
    parameter int PULSE_CYCLES = siodc_pkg::DRDY_PULSE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sample_tick,
    input wire logic enable,
    output logic pulse
);

    localparam int CW = $clog2(PULSE_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(PULSE_CYCLES - 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] cnt;
    } siodc_pulse_t;

    siodc_pulse_t s;
    siodc_pulse_t next_s;

    // ==========================================================
    // Pulse timing
    // ==========================================================
    // A tick during a running pulse is ignored so the width never leaves its window.
    always_comb begin
        next_s = s;
        if (s.busy) begin
            if (s.cnt == '0) begin
                next_s.busy = 1'b0;
            end else begin
                next_s.cnt = s.cnt - CW'(1);
            end
        end else if (sample_tick && enable) begin // RULE_06
            next_s.busy = 1'b1;
            next_s.cnt = LOAD; // RULE_05
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pulse = s.busy;

endmodule

// file: siodc_core.sv
// Serial register bank for digital lines, data ready, analog out code and diagnostics.
// Function
// RULE_01: Line role priority: data ready, then alarm output, then general-purpose control.
// RULE_02: Line register bits 0 and 1 set directions; one means output.
// RULE_03: Line register bits 8 and 9 hold levels driven on output lines.
// RULE_04: Misc bit 2 enables data ready, bit 1 polarity, bit 0 selects line.
// RULE_05: Data-ready pulse lasts between 100 and 200 microseconds.
// RULE_06: One data-ready pulse per new output sample.
// RULE_07: Analog out code is 12-bit offset binary in bits 11 to 0.
// RULE_08: Code writes stay buffered until the latch copies the whole register.
// RULE_09: Host writes low byte, then high byte, then issues the latch.
// RULE_10: Misc bit 10 runs automatic self-test, then clears itself.
// RULE_11: Diagnostic bit 5 reports self-test failure.
// RULE_12: Misc bits 9 and 8 apply negative and positive stimulus while set.
// RULE_13: Misc bit 11 runs memory checksum test, clears, reports in bit 6.
// RULE_14: Reading diagnostic flags clears all error flags except supply flags.
// RULE_15: A persisting error sets its flag again on the next sample.
// RULE_16: Bits 1 and 0 track supply high and low, clearing by themselves.
// RULE_17: Bits 9 and 8 show alarm two and alarm one active.
// RULE_18: Bits 4, 3, 2 flag overrange, serial failure, flash update failure.
// RULE_19: Host waits about 50 ms after stimulus changes and clears stimulus after.
// RULE_20: Input lines read the sampled pin; written levels are not driven.
// RULE_21: Global command bit 2 latches the code and clears after completion.
// RULE_22: Alarm control bit 2 enables, bit 1 polarity, bit 0 selects line.
`timescale 1ns/1ps

module siodc_core #(
    parameter int DRDY_PULSE_CYCLES = siodc_pkg::DRDY_PULSE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [1:0] dio_in,
    output logic [1:0] dio_out,
    output logic [1:0] dio_oe,
    input wire logic sample_tick,
    input wire logic alarm1_active,
    input wire logic alarm2_active,
    input wire logic overrange,
    input wire logic flash_update_fail,
    input wire logic supply_high,
    input wire logic supply_low,
    output logic stim_pos,
    output logic stim_neg,
    output logic self_test_req,
    input wire logic self_test_done,
    input wire logic self_test_fail,
    output logic mem_test_req,
    input wire logic mem_test_done,
    input wire logic mem_test_fail,
    output logic [11:0] dac_code
);

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] cs_s;
        logic [1:0] mosi_s;
        logic [1:0] dio_s1;
        logic [1:0] dio_s2;
        logic [15:0] rx;
        logic [4:0] cnt;
        logic [15:0] tx;
        logic [15:0] tx_pend;
        logic [15:0] line_dir_lvl;
        logic [15:0] misc;
        logic [11:0] dac_hold;
        logic [11:0] dac_out;
        logic [2:0] alarm_ctl;
        logic dac_latch;
        logic [15:0] diag;
        siodc_pkg::siodc_test_t test_state;
        logic st_req;
        logic mem_req;
        logic [1:0] dio_out;
        logic [1:0] dio_oe;
    } siodc_core_t;

    siodc_core_t s;
    siodc_core_t next_s;
    logic ready_pulse;

    // ==========================================================
    // Data-ready pulse source
    // ==========================================================
    siodc_ready_pulse #(
        .PULSE_CYCLES(DRDY_PULSE_CYCLES)
    ) u_ready (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample_tick(sample_tick),
        .enable(s.misc[siodc_pkg::MISC_READY_EN]),
        .pulse(ready_pulse)
    );

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic sclk_rise;
        logic sclk_fall;
        logic cs_fall;
        logic cs_rise;
        logic frame_ok;
        logic [6:0] addr;
        logic [6:0] reg_base;
        logic [7:0] wdata;
        logic [15:0] rdata;
        logic [1:0] line_lvl;
        logic ready_lvl;
        logic alarm_lvl;
        sclk_rise = 1'b0;
        sclk_fall = 1'b0;
        cs_fall = 1'b0;
        cs_rise = 1'b0;
        frame_ok = 1'b0;
        addr = '0;
        reg_base = '0;
        wdata = '0;
        rdata = '0;
        line_lvl = '0;
        ready_lvl = 1'b0;
        alarm_lvl = 1'b0;
        next_s = s;

        // Pins come from outside the clock domain, so each goes through two stages; clock and select get a third for edge detection.
        next_s.sclk_s = {s.sclk_s[1:0], spi_sclk};
        next_s.cs_s = {s.cs_s[1:0], spi_cs_n};
        next_s.mosi_s = {s.mosi_s[0], spi_mosi};
        next_s.dio_s1 = dio_in;
        next_s.dio_s2 = s.dio_s1;

        sclk_rise = s.sclk_s[1] && !s.sclk_s[2];
        sclk_fall = !s.sclk_s[1] && s.sclk_s[2];
        cs_fall = !s.cs_s[1] && s.cs_s[2];
        cs_rise = s.cs_s[1] && !s.cs_s[2];

        // ======================================================
        // Serial shifter, clock idles high, sampled on rising edges
        // ======================================================
        if (cs_fall) begin
            next_s.tx = s.tx_pend;
            next_s.cnt = '0;
        end else if (!s.cs_s[1]) begin
            if (sclk_rise) begin
                next_s.rx = {s.rx[14:0], s.mosi_s[1]};
                if (s.cnt != 5'h1F) begin
                    next_s.cnt = s.cnt + 5'h01;
                end
            end
            // The first falling edge only starts the frame; the top bit is already out.
            if (sclk_fall && s.cnt != '0) begin
                next_s.tx = {s.tx[14:0], 1'b0};
            end
        end
        frame_ok = cs_rise && (s.cnt == siodc_pkg::FRAME_LEN);

        // ======================================================
        // Register access at the end of a complete frame
        // ======================================================
        addr = s.rx[14:8];
        reg_base = {addr[6:1], 1'b0};
        wdata = s.rx[7:0];
        for (int i = 0; i < 2; i++) begin
            line_lvl[i] = s.line_dir_lvl[siodc_pkg::LINE_DIR_LSB + i] ?
                s.line_dir_lvl[siodc_pkg::LINE_LVL_LSB + i] : s.dio_s2[i]; // RULE_20
        end
        case (reg_base)
            siodc_pkg::ADDR_LINE_DIRECTION_LEVEL: rdata = {6'h00, line_lvl, 6'h00,
                s.line_dir_lvl[siodc_pkg::LINE_DIR_LSB +: 2]};
            siodc_pkg::ADDR_MISC_TEST_READY_CONTROL: rdata = s.misc;
            siodc_pkg::ADDR_ANALOG_OUT_CODE: rdata = {4'h0, s.dac_hold};
            siodc_pkg::ADDR_ALARM_CONTROL: rdata = {13'h0000, s.alarm_ctl};
            siodc_pkg::ADDR_GLOBAL_COMMAND: begin
                rdata = 16'(s.dac_latch) << siodc_pkg::GLOBAL_DAC_LATCH;
            end
            siodc_pkg::ADDR_DIAGNOSTIC_FLAGS: rdata = s.diag;
            default: rdata = 16'h0000;
        endcase

        if (frame_ok && s.rx[siodc_pkg::FRAME_WRITE_BIT]) begin
            case (reg_base)
                siodc_pkg::ADDR_LINE_DIRECTION_LEVEL: begin // RULE_02 RULE_03
                    next_s.line_dir_lvl[{addr[0], 3'h0} +: 8] = wdata;
                    next_s.line_dir_lvl = next_s.line_dir_lvl & siodc_pkg::LINE_MASK;
                end
                siodc_pkg::ADDR_MISC_TEST_READY_CONTROL: begin // RULE_04 RULE_12
                    next_s.misc[{addr[0], 3'h0} +: 8] = wdata;
                    next_s.misc = next_s.misc & siodc_pkg::MISC_MASK;
                end
                siodc_pkg::ADDR_ANALOG_OUT_CODE: begin // RULE_07 RULE_09
                    if (addr[0]) begin
                        next_s.dac_hold[11:8] = wdata[3:0];
                    end else begin
                        next_s.dac_hold[7:0] = wdata;
                    end
                end
                siodc_pkg::ADDR_ALARM_CONTROL: begin // RULE_22
                    if (!addr[0]) begin
                        next_s.alarm_ctl = wdata[2:0];
                    end
                end
                siodc_pkg::ADDR_GLOBAL_COMMAND: begin // RULE_21
                    if (!addr[0] && wdata[siodc_pkg::GLOBAL_DAC_LATCH]) begin
                        next_s.dac_latch = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (frame_ok) begin
            // A read returns its data during the following frame.
            next_s.tx_pend = rdata;
            if (reg_base == siodc_pkg::ADDR_DIAGNOSTIC_FLAGS) begin
                next_s.diag = '0; // RULE_14
            end
        end

        // ======================================================
        // Converter latch and self-test / memory-test sequencer
        // ======================================================
        if (s.dac_latch) begin
            next_s.dac_out = s.dac_hold; // RULE_08
            next_s.dac_latch = 1'b0; // RULE_21
        end

        case (s.test_state)
            siodc_pkg::SIODC_IDLE: begin
                if (s.misc[siodc_pkg::MISC_SELF_TEST]) begin // RULE_10
                    next_s.st_req = 1'b1;
                    next_s.test_state = siodc_pkg::SIODC_SELF;
                end else if (s.misc[siodc_pkg::MISC_MEM_TEST]) begin // RULE_13
                    next_s.mem_req = 1'b1;
                    next_s.test_state = siodc_pkg::SIODC_MEM;
                end
            end
            siodc_pkg::SIODC_SELF: begin
                if (self_test_done) begin
                    next_s.st_req = 1'b0;
                    next_s.diag[siodc_pkg::DIAG_SELF_TEST] = self_test_fail; // RULE_11
                    next_s.misc[siodc_pkg::MISC_SELF_TEST] = 1'b0; // RULE_10
                    next_s.test_state = siodc_pkg::SIODC_IDLE;
                end
            end
            siodc_pkg::SIODC_MEM: begin
                if (mem_test_done) begin
                    next_s.mem_req = 1'b0;
                    next_s.diag[siodc_pkg::DIAG_MEM_TEST] = mem_test_fail; // RULE_13
                    next_s.misc[siodc_pkg::MISC_MEM_TEST] = 1'b0;
                    next_s.test_state = siodc_pkg::SIODC_IDLE;
                end
            end
            default: begin
                next_s.st_req = 1'b0;
                next_s.mem_req = 1'b0;
                next_s.test_state = siodc_pkg::SIODC_IDLE;
            end
        endcase

        // ======================================================
        // Diagnostic flags; every set is applied after the read clear
        // ======================================================
        if (cs_rise && s.cnt != '0 && s.cnt != siodc_pkg::FRAME_LEN) begin
            next_s.diag[siodc_pkg::DIAG_COMM_FAIL] = 1'b1; // RULE_18
        end
        if (sample_tick) begin // RULE_15
            next_s.diag[siodc_pkg::DIAG_OVERRANGE] |= overrange; // RULE_18
            next_s.diag[siodc_pkg::DIAG_FLASH_UPDATE] |= flash_update_fail; // RULE_18
            next_s.diag[siodc_pkg::DIAG_ALARM1] |= alarm1_active; // RULE_17
            next_s.diag[siodc_pkg::DIAG_ALARM2] |= alarm2_active; // RULE_17
        end
        next_s.diag[siodc_pkg::DIAG_SUPPLY_HIGH] = supply_high; // RULE_16
        next_s.diag[siodc_pkg::DIAG_SUPPLY_LOW] = supply_low; // RULE_16

        // ======================================================
        // Digital line roles
        // ======================================================
        ready_lvl = s.misc[siodc_pkg::MISC_READY_POL] ? ready_pulse : !ready_pulse;
        alarm_lvl = (alarm1_active || alarm2_active) ~^ s.alarm_ctl[siodc_pkg::ALARM_POL];
        for (int i = 0; i < 2; i++) begin
            if (s.misc[siodc_pkg::MISC_READY_EN] &&
                    s.misc[siodc_pkg::MISC_READY_SEL] == 1'(i)) begin // RULE_01 RULE_04
                next_s.dio_oe[i] = 1'b1;
                next_s.dio_out[i] = ready_lvl; // RULE_05
            end else if (s.alarm_ctl[siodc_pkg::ALARM_EN] &&
                    s.alarm_ctl[siodc_pkg::ALARM_SEL] == 1'(i)) begin // RULE_01 RULE_22
                next_s.dio_oe[i] = 1'b1;
                next_s.dio_out[i] = alarm_lvl;
            end else begin // RULE_01 RULE_02 RULE_03 RULE_20
                next_s.dio_oe[i] = s.line_dir_lvl[siodc_pkg::LINE_DIR_LSB + i];
                next_s.dio_out[i] = s.line_dir_lvl[siodc_pkg::LINE_LVL_LSB + i];
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.sclk_s <= 3'h7;
            s.cs_s <= 3'h7;
            s.line_dir_lvl <= siodc_pkg::LINE_RST;
            s.misc <= siodc_pkg::MISC_RST;
            s.dac_hold <= siodc_pkg::DAC_RST;
            s.dac_out <= siodc_pkg::DAC_RST;
            s.alarm_ctl <= siodc_pkg::ALARM_RST;
            s.diag <= siodc_pkg::DIAG_RST;
            s.test_state <= siodc_pkg::SIODC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // The serial clock must be slower than a quarter of sys_clk for the samplers.
    assign spi_miso = s.tx[15];
    assign spi_miso_oe = !s.cs_s[1];
    assign dio_out = s.dio_out;
    assign dio_oe = s.dio_oe;
    assign stim_pos = s.misc[siodc_pkg::MISC_STIM_POS]; // RULE_12
    assign stim_neg = s.misc[siodc_pkg::MISC_STIM_NEG]; // RULE_12
    assign self_test_req = s.st_req;
    assign mem_test_req = s.mem_req;
    assign dac_code = s.dac_out; // RULE_08

endmodule

// file: siodc_core_sva.sv
// Port-level assertions for the sensor line, diagnostic and control block.
`timescale 1ns/1ps
module siodc_core_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic sample_tick,
    input wire logic [1:0] dio_out,
    input wire logic [1:0] dio_oe,
    input wire logic stim_pos,
    input wire logic stim_neg,
    input wire logic self_test_req,
    input wire logic self_test_done,
    input wire logic mem_test_req,
    input wire logic mem_test_done,
    input wire logic [11:0] dac_code
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_self_end;
        self_test_req && self_test_done;
    endsequence
    sequence s_mem_end;
        mem_test_req && mem_test_done;
    endsequence
    sequence s_ready_start;
        $rose(dio_out[1]) && dio_oe[1] && $past(sample_tick, 2);
    endsequence
    a_self_test_end: assert property (s_self_end |=> !self_test_req)
        else $error("Self-test request held after done.");
    a_self_test_hold: assert property (self_test_req && !self_test_done |=> self_test_req)
        else $error("Self-test request dropped early.");
    a_self_test_start: assert property ($rose(self_test_req) |-> $past(spi_cs_n, 3))
        else $error("Self-test started without a frame.");
    a_mem_test_end: assert property (s_mem_end |=> !mem_test_req)
        else $error("Memory request held after done.");
    a_test_req_excl: assert property (!(self_test_req && mem_test_req))
        else $error("Both test requests active.");
    a_dac_after_frame: assert property ($changed(dac_code) |-> $past(spi_cs_n, 4))
        else $error("Converter code moved outside a latch.");
    a_stim_after_frame: assert property ($changed({stim_neg, stim_pos}) |-> $past(spi_cs_n, 3))
        else $error("Stimulus changed without a frame.");
    a_ready_min_width: assert property (s_ready_start |=> $stable(dio_out[1])[*8])
        else $error("Ready pulse too short.");
endmodule
bind siodc_core siodc_core_sva siodc_core_sva_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .sample_tick(sample_tick),
    .dio_out(dio_out), .dio_oe(dio_oe), .stim_pos(stim_pos), .stim_neg(stim_neg),
    .self_test_req(self_test_req), .self_test_done(self_test_done),
    .mem_test_req(mem_test_req), .mem_test_done(mem_test_done), .dac_code(dac_code));

// file: siodc_host_model.sv
// Host serial master model, mode 3, driving frames into the block.
`timescale 1ns/1ps
module siodc_host_model (
    input wire logic sys_clk,
    input wire logic spi_miso,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi
);
    // Half period of six system clocks keeps clear of the synchroniser limit.
    localparam int HALF = 6;
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end
    task automatic xfer(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        spi_cs_n = 1'b0;
        repeat (HALF) @(negedge sys_clk);
        for (int i = 0; i < nbits; i++) begin
            spi_sclk = 1'b0;
            spi_mosi = tx[15 - i];
            repeat (HALF) @(negedge sys_clk);
            rx = {rx[14:0], spi_miso};
            spi_sclk = 1'b1;
            repeat (HALF) @(negedge sys_clk);
        end
        spi_cs_n = 1'b1;
        // A deselected data line must not keep looking valid.
        spi_mosi = ~spi_mosi;
        repeat (HALF) @(negedge sys_clk);
    endtask
endmodule

// file: siodc_bench.sv
// Self-checking bench for the sensor line, diagnostic and control block.
`timescale 1ns/1ps
module siodc_bench;
    localparam int PULSE = 20;
    typedef struct packed {
        logic [15:0] val;
        logic [1:0] oe;
        logic [1:0] out;
        logic [15:0] rb;
    } siodc_row_t;
    localparam siodc_row_t ROWS [4] = '{'{16'h0202, 2'h2, 2'h2, 16'h0202},
        '{16'h0101, 2'h1, 2'h1, 16'h0301}, '{16'h0300, 2'h0, 2'h3, 16'h0200},
        '{16'h0003, 2'h3, 2'h0, 16'h0003}};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic [1:0] dio_in = 2'h2;
    logic [1:0] dio_out, dio_oe;
    logic sample_tick = 1'b0, alarm1_active = 1'b1, alarm2_active = 1'b0;
    logic overrange = 1'b0, flash_update_fail = 1'b0, supply_high = 1'b0, supply_low = 1'b0;
    logic self_test_done = 1'b0, self_test_fail = 1'b0, mem_test_done = 1'b0;
    logic mem_test_fail = 1'b0, stim_pos, stim_neg, self_test_req, mem_test_req;
    logic [11:0] dac_code;
    logic [15:0] rx, v;
    int num_errors = 0, compares = 0, cyc = 0, w;
    siodc_core #(.DRDY_PULSE_CYCLES(PULSE)) siodc_core_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
        .sample_tick(sample_tick), .alarm1_active(alarm1_active), .alarm2_active(alarm2_active),
        .overrange(overrange), .flash_update_fail(flash_update_fail), .supply_high(supply_high),
        .supply_low(supply_low), .stim_pos(stim_pos), .stim_neg(stim_neg),
        .self_test_req(self_test_req), .self_test_done(self_test_done),
        .self_test_fail(self_test_fail), .mem_test_req(mem_test_req),
        .mem_test_done(mem_test_done), .mem_test_fail(mem_test_fail), .dac_code(dac_code));
    siodc_host_model siodc_host_model_inst (.sys_clk(sys_clk), .spi_miso(spi_miso),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        siodc_host_model_inst.xfer(16, {1'b1, a, d}, rx);
    endtask
    // Read data comes back one frame late, so a dummy frame collects it.
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        siodc_host_model_inst.xfer(16, {1'b0, a, 8'h00}, rx);
        siodc_host_model_inst.xfer(16, 16'h0000, d);
    endtask
    task automatic tick;
        sample_tick = 1'b1;
        @(negedge sys_clk);
        sample_tick = 1'b0;
    endtask
    task automatic test_done;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            test_done();
        end
    end
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({4'h0, dac_code}, 16'h0000);
        chk({11'h0, spi_miso_oe, dio_oe, self_test_req, mem_test_req}, 16'h0000);
        rd(siodc_pkg::ADDR_MISC_TEST_READY_CONTROL, v);
        chk(v, 16'h0000);
        rd(7'h40, v);
        chk(v, 16'h0000);
        foreach (ROWS[i]) begin
            wr(siodc_pkg::ADDR_LINE_DIRECTION_LEVEL, ROWS[i].val[7:0]);
            wr(siodc_pkg::ADDR_LINE_DIRECTION_LEVEL + 7'h01, ROWS[i].val[15:8]);
            chk({14'h0, dio_oe}, {14'h0, ROWS[i].oe});
            chk({14'h0, dio_out}, {14'h0, ROWS[i].out});
            rd(siodc_pkg::ADDR_LINE_DIRECTION_LEVEL, v);
            chk(v, ROWS[i].rb);
        end
        wr(siodc_pkg::ADDR_LINE_DIRECTION_LEVEL, 8'h00);
        wr(siodc_pkg::ADDR_ALARM_CONTROL, 8'h07);
        chk({14'h0, dio_oe, dio_out}, 16'h000A);
        wr(siodc_pkg::ADDR_MISC_TEST_READY_CONTROL, 8'h07);
        chk({14'h0, dio_oe, dio_out}, 16'h0008);
        for (int k = 0; k < 2; k++) begin
            tick();
            @(negedge sys_clk);
            w = 0;
            while (dio_out[1] === 1'b1 && w < 100) begin
                @(negedge sys_clk);
                w++;
            end
            chk(16'(w), 16'(PULSE));
        end
        wr(siodc_pkg::ADDR_ANALOG_OUT_CODE, 8'hCC);
        wr(siodc_pkg::ADDR_ANALOG_OUT_CODE + 7'h01, 8'h0C);
        chk({4'h0, dac_code}, 16'h0000);
        wr(siodc_pkg::ADDR_GLOBAL_COMMAND, 8'h04);
        repeat (4) @(negedge sys_clk);
        chk({4'h0, dac_code}, 16'h0CCC);
        rd(siodc_pkg::ADDR_GLOBAL_COMMAND, v);
        chk(v, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            wr(siodc_pkg::ADDR_MISC_TEST_READY_CONTROL + 7'h01, 8'(2 - k));
            chk({14'h0, stim_neg, stim_pos}, 16'(2 - k));
        end
        self_test_fail = 1'b1;
        mem_test_fail = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(siodc_pkg::ADDR_MISC_TEST_READY_CONTROL + 7'h01, k ? 8'h08 : 8'h04);
            chk({14'h0, mem_test_req, self_test_req}, k ? 16'h0002 : 16'h0001);
            self_test_done = (k == 0);
            mem_test_done = (k == 1);
            @(negedge sys_clk);
            self_test_done = 1'b0;
            mem_test_done = 1'b0;
            rd(siodc_pkg::ADDR_MISC_TEST_READY_CONTROL, v);
            chk(v, 16'h0007);
        end
        overrange = 1'b1;
        flash_update_fail = 1'b1;
        supply_high = 1'b1;
        tick();
        rd(siodc_pkg::ADDR_DIAGNOSTIC_FLAGS, v);
        chk(v, 16'h0176);
        rd(siodc_pkg::ADDR_DIAGNOSTIC_FLAGS, v);
        chk(v, 16'h0002);
        supply_high = 1'b0;
        alarm1_active = 1'b0;
        flash_update_fail = 1'b0;
        siodc_host_model_inst.xfer(8, 16'hFFFF, rx);
        tick();
        rd(siodc_pkg::ADDR_DIAGNOSTIC_FLAGS, v);
        chk(v, 16'h0018);
        test_done();
    end
endmodule
